// [bench/sdram_hold_props.sv]
// assertions on the link between the memory port end and the bus arbiter
`timescale 1ns/1ps
module sdram_hold_props
  import sdram_hold_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // hold and refresh marks
  input wire logic holdReq,
  input wire logic holdAck,
  input wire logic refreshPending,
  input wire logic refreshStart,
  input wire logic refreshEnd,
  // memory port pins
  input wire logic [2:0] memCmdN,
  input wire logic memAllBanks,
  input wire logic memCmdOe,
  input wire logic memDataOe,
  input wire logic directStrobeN,
  input wire logic directStrobeAN,
  input wire logic directDirection
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================================
  // handover steps
  // a deactivate or a grant inside tRFC would cut the refresh short
  sequence quiet;
    memCmdN != CMD_DEACT && !holdAck;
  endsequence
  sequence deactDone;
    $past(memCmdN) == CMD_DEACT && $past(memAllBanks);
  endsequence
  logic isRefresh;
  assign isRefresh = memCmdOe && memCmdN == CMD_REFRESH;

  // ==========================================================
  // memory port end
  // the deactivate may come T_RFC_CYC (9) cycles after the refresh, so the eight cycles between stay quiet
  chk_rfc_no_deact: assert property (isRefresh |=> quiet [*8])
    else $error("deactivate or grant inside refresh time");
  chk_grant_after_deact: assert property ($rose(holdAck) |-> deactDone)
    else $error("grant without deactivate just before");
  chk_grant_frees_pins: assert property (holdAck |-> !memCmdOe && !memDataOe && directStrobeN)
    else $error("pins driven while bus granted");
  chk_release_retakes: assert property ($fell(holdAck) |-> memCmdOe)
    else $error("command pins not retaken on release");
  chk_refresh_not_held: assert property (isRefresh |-> !holdAck)
    else $error("refresh issued while bus granted");
  chk_direct_pins: assert property (!directStrobeN |-> !directStrobeAN && directDirection && !memDataOe)
    else $error("direct strobes without matching pins");
  chk_direct_on_write: assert property ($fell(directStrobeN) |-> memCmdN == CMD_WRITE && memCmdOe)
    else $error("direct strobe not started with write");

  // ==========================================================
  // arbiter end
  chk_pending_backoff: assert property ($rose(refreshPending) |-> ##4 !holdReq [*8])
    else $error("hold kept up after pending refresh");
  chk_start_backoff: assert property (refreshStart |-> ##4 !holdReq [*4])
    else $error("hold up inside refresh marks");
  chk_end_after_start: assert property (refreshStart |-> ##[7:10] refreshEnd)
    else $error("refresh end mark missing");
endmodule

// [bench/sdram_hold_refresh_pdt_ctrl_tb_top.sv]
// self-checking bench joining the memory port end and the arbiter end
`timescale 1ns/1ps
module sdram_hold_refresh_pdt_ctrl_tb_top
  import sdram_hold_pkg::*;
;
  logic clk, nrst, ce, wrValid, wrDirect, wrReady, busWanted, busOwned;
  logic [1:0] dwl, wrBank;
  logic [31:0] wrData;
  refresh_scheme_t sch;
  int errorCnt, samplesChecked, devRef, arbRef, starts, ends, r0, a0, s0, e0;

  // ==========================================================
  // the two ends and the checker
  sdram_link_if #(.DATA_W(32)) link();
  sdram_hold_dev sdram_hold_dev_inst (.clk(clk), .nrst(nrst), .ce(ce), .link(link.device_end),
    .scheme(sch), .directWriteLatency(dwl), .wrValid(wrValid), .wrDirect(wrDirect),
    .wrBank(wrBank), .wrData(wrData), .wrReady(wrReady));
  // the arbiter owns the hold request
  sdram_hold_arb sdram_hold_arb_inst (.clk(clk), .nrst(nrst), .ce(ce), .link(link.arbiter_end),
    .scheme(sch), .busWanted(busWanted), .busOwned(busOwned));
  sdram_hold_props sdram_hold_props_inst (.clk(clk), .nrst(nrst), .holdReq(link.holdReq),
    .holdAck(link.holdAck), .refreshPending(link.refreshPending), .refreshStart(link.refreshStart),
    .refreshEnd(link.refreshEnd), .memCmdN(link.memCmdN), .memAllBanks(link.memAllBanks),
    .memCmdOe(link.memCmdOe), .memDataOe(link.memDataOe), .directStrobeN(link.directStrobeN),
    .directStrobeAN(link.directStrobeAN), .directDirection(link.directDirection));

  // ==========================================================
  // clock and event counters
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (nrst && link.memCmdOe && link.memCmdN == CMD_REFRESH) devRef++;
    if (nrst && link.arbCmdOe && link.arbCmdN == CMD_REFRESH) arbRef++;
    if (nrst && link.refreshStart) starts++;
    if (nrst && link.refreshEnd) ends++;
  end

  // ==========================================================
  // tasks
  task tallyAndFinish();
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? wrReady : w == 1 ? busOwned : link.holdAck;
  endfunction
  // bounded wait; running out ends the run, a hang tells nothing more
  task automatic waitSig(input int w, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(w) !== v && n < lim);
    if (pick(w) !== v) begin
      errorCnt++;
      $display("FAIL %0t: wait ran out", $time);
      tallyAndFinish();
    end
  endtask
  task automatic rst(input refresh_scheme_t s);
    nrst <= 1'h0;
    sch <= s;
    busWanted <= 1'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    check(link.holdAck, 1'h0);
    check(link.memCmdN, CMD_NOP);
  endtask
  // one write; gap is the turnaround cycle before a direct write
  task automatic wr(input logic d, input logic [1:0] b, input logic [31:0] v, input int gap);
    wrValid <= 1'h1;
    wrDirect <= d;
    wrBank <= b;
    wrData <= v;
    waitSig(0, 1'h1, 2000);
    wrValid <= 1'h0;
    repeat (gap + 1) @(posedge clk);
    check(link.memCmdN, CMD_WRITE);
    check(link.memBank, b);
    if (!d) begin
      check(link.memDataOe, 1'h1);
      check(link.memDataOut, v);
    end else begin
      repeat (dwl + 1) begin
        check(link.directStrobeN, 1'h0);
        check(link.directDirection, 1'h1);
        @(posedge clk);
      end
    end
    check(link.directStrobeN, 1'h1);
    repeat (3) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    nrst = 1'h0;
    ce = 1'h1;
    sch = SCH_PENDING;
    dwl = 2'h0;
    wrValid = 1'h0;
    wrDirect = 1'h0;
    wrBank = 2'h0;
    wrData = 32'h0;
    busWanted = 1'h0;
    rst(SCH_PENDING);
    // latency three is never set when writes are mixed
    for (int l = 0; l < 3; l++) begin
      dwl <= 2'(l);
      @(posedge clk);
      wr(1'h0, 2'h0, 32'ha5a5_0000 + l, 0);
      wr(1'h1, 2'h1, 32'h5a5a_0001, 1);
      wr(1'h1, 2'h1, 32'h5a5a_0002, 0);
      wr(1'h0, 2'h1, 32'hffff_0000, 0);
      wr(1'h1, 2'h1, 32'h0000_ffff, 0);
    end
    // long hold: pending mark must still get refreshes through
    r0 = devRef;
    busWanted <= 1'h1;
    waitSig(1, 1'h1, 100);
    check(link.memCmdOe, 1'h0);
    repeat (2100) @(posedge clk);
    check(devRef - r0 >= 2, 1'h1);
    busWanted <= 1'h0;
    waitSig(2, 1'h0, 40);
    // short holds at shifting phases so requests collide with refresh
    rst(SCH_START_END);
    r0 = devRef;
    s0 = starts;
    e0 = ends;
    for (int i = 0; i < 50; i++) begin
      busWanted <= 1'h1;
      waitSig(1, 1'h1, 100);
      repeat (37) @(posedge clk);
      busWanted <= 1'h0;
      waitSig(2, 1'h0, 40);
      repeat (1 + i % 7) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    check(devRef - r0 >= 2, 1'h1);
    check(starts - s0 >= 2, 1'h1);
    check(ends - e0, starts - s0);
    // arbiter refreshes, device refresh stays off
    rst(SCH_ARBITER);
    r0 = devRef;
    a0 = arbRef;
    busWanted <= 1'h1;
    repeat (2200) @(posedge clk);
    busWanted <= 1'h0;
    repeat (20) @(posedge clk);
    check(devRef - r0, 0);
    check(arbRef - a0 >= 2, 1'h1);
    tallyAndFinish();
  end
endmodule

// [hw/sdram_hold_arb.sv]
// external bus arbiter end: hold requests kept clear of sdram refresh
`timescale 1ns/1ps
module sdram_hold_arb
  import sdram_hold_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // link
  sdram_link_if.arbiter_end link,
  // user side
  input wire refresh_scheme_t scheme,
  input wire logic busWanted,
  output logic busOwned
);
  // ==========================================================
  // synchronisers for the device outputs
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic pendPrev;
  logic ackS, pendS, startS, endS;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      pendPrev <= 1'b0;
    end else if (ce) begin
      sync1 <= {link.holdAck, link.refreshPending, link.refreshStart, link.refreshEnd};
      sync2 <= sync1;
      pendPrev <= sync2[2];
    end
  end
  assign {ackS, pendS, startS, endS} = sync2;

  // ==========================================================
  // hold control state
  logic holdReq, next_holdReq;
  logic blocked, next_blocked;
  logic [WAIT_W-1:0] timer, next_timer;
  logic [REFI_W-1:0] refiCnt, next_refiCnt;
  logic refDue, next_refDue;
  logic refBusy, next_refBusy;
  logic [2:0] cmdN, next_cmdN;
  logic cmdOe, next_cmdOe;
  logic owned, next_owned;

  // next values; refresh needs take precedence over the user's wish for the bus
  always_comb begin
    next_holdReq = holdReq;
    next_blocked = blocked;
    next_timer = timer;
    next_refiCnt = refiCnt;
    next_refDue = refDue;
    next_refBusy = refBusy;
    next_cmdN = CMD_NOP;
    next_cmdOe = 1'b0;
    if (timer != '0) begin
      next_timer = timer - 1'b1;
    end
    case (scheme)
      SCH_ARBITER: begin
        // own refresh interval and own tRFC guarantee
        next_blocked = 1'b0;
        if (refiCnt == REFI_W'(T_REFI_CYC - 1)) begin
          next_refiCnt = '0;
          next_refDue = 1'b1;
        end else begin
          next_refiCnt = refiCnt + 1'b1;
        end
        if (refDue && !refBusy && ackS && holdReq) begin
          next_cmdN = CMD_REFRESH;
          next_cmdOe = 1'b1;
          next_refBusy = 1'b1;
          next_timer = WAIT_W'(T_RFC_CYC);
          next_refDue = (refiCnt == REFI_W'(T_REFI_CYC - 1));
        end else if (refBusy) begin
          next_cmdOe = 1'b1;
          if (timer == '0) begin
            next_refBusy = 1'b0;
          end
        end
      end
      SCH_PENDING: begin
        // drop hold on a pending refresh, wait out own estimate
        if (pendS && !pendPrev) begin
          next_blocked = 1'b1;
          next_timer = WAIT_W'(ARB_DONE_CYC);
        end else if (blocked && timer == '0 && !pendS) begin
          next_blocked = 1'b0;
        end
      end
      SCH_START_END: begin
        // keep hold off between start and end marks
        if (startS) begin
          next_blocked = 1'b1;
        end else if (endS) begin
          next_blocked = 1'b0;
        end
      end
      default: begin
        next_blocked = 1'b1;
      end
    endcase
    // this logic alone controls the hold request
    next_holdReq = !next_blocked && (busWanted || next_refDue || next_refBusy);
    next_owned = ackS && holdReq && next_holdReq;
  end

  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      holdReq <= 1'b0;
      blocked <= 1'b0;
      timer <= '0;
      refiCnt <= '0;
      refDue <= 1'b0;
      refBusy <= 1'b0;
      cmdN <= CMD_NOP;
      cmdOe <= 1'b0;
      owned <= 1'b0;
    end else if (ce) begin
      holdReq <= next_holdReq;
      blocked <= next_blocked;
      timer <= next_timer;
      refiCnt <= next_refiCnt;
      refDue <= next_refDue;
      refBusy <= next_refBusy;
      cmdN <= next_cmdN;
      cmdOe <= next_cmdOe;
      owned <= next_owned;
    end
  end

  assign link.holdReq = holdReq;
  assign link.arbCmdN = cmdN;
  assign link.arbCmdOe = cmdOe;
  assign busOwned = owned;
endmodule

// [hw/sdram_hold_dev.sv]
// memory port end: refresh versus bus hold, and direct-write strobe sequencing
//
// Overview of operation
// - refresh due wins over a new hold request
// - no deactivate or hold ack before tRFC
// - external arbitration logic owns the hold request
// - arbiter scheme: arbiter refreshes, internal refresh off
// - pending output; arbiter drops hold, times completion
// - start and end marks; hold off between
// - direct write after normal write drives pins cleanly
// - software avoids direct write latency three when mixing
`timescale 1ns/1ps
module sdram_hold_dev
  import sdram_hold_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // link
  sdram_link_if.device_end link,
  // configuration
  input wire refresh_scheme_t scheme,
  input wire logic [1:0] directWriteLatency,
  // write requests
  input wire logic wrValid,
  input wire logic wrDirect,
  input wire logic [1:0] wrBank,
  input wire logic [DATA_W-1:0] wrData,
  output logic wrReady
);
  initial begin
    if (DATA_W < 1 || DATA_W > 64) begin
      $error("DATA_W out of range");
    end
    if (T_RFC_CYC >= (1 << WAIT_W) || T_REFI_CYC >= (1 << REFI_W)) begin
      $error("timing counters too narrow");
    end
  end

  // ==========================================================
  // hold request comes from the other party: two flip-flops first
  logic holdSync1, holdSync2;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      holdSync1 <= 1'b0;
      holdSync2 <= 1'b0;
    end else if (ce) begin
      holdSync1 <= link.holdReq;
      holdSync2 <= holdSync1;
    end
  end

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RFC = 3'h1,
    ST_DEACT = 3'h2,
    ST_HELD = 3'h3,
    ST_TURN = 3'h4,
    ST_WRITE = 3'h5,
    ST_DLAT = 3'h6
  } dev_state_t;

  dev_state_t state, next_state;
  logic [REFI_W-1:0] refiCnt, next_refiCnt;
  logic refreshDue, next_refreshDue;
  logic [WAIT_W-1:0] waitCnt, next_waitCnt;
  logic [1:0] latCnt, next_latCnt;
  logic holdAck, next_holdAck;
  logic [2:0] cmdN, next_cmdN;
  logic allBanks, next_allBanks;
  logic [1:0] bankOut, next_bankOut;
  logic cmdOe, next_cmdOe;
  logic [DATA_W-1:0] dataOut, next_dataOut;
  logic dataOe, next_dataOe;
  logic strobeN, next_strobeN;
  logic strobeAN, next_strobeAN;
  logic direction, next_direction;
  logic pending, next_pending;
  logic startMark, next_startMark;
  logic endMark, next_endMark;
  logic ready, next_ready;
  logic lastNormal, next_lastNormal;
  logic [1:0] lastBank, next_lastBank;
  logic curDirect, next_curDirect;
  logic [1:0] curBank, next_curBank;
  logic [DATA_W-1:0] curData, next_curData;
  logic refiExpire;

  // ==========================================================
  // next values
  always_comb begin
    next_state = state;
    next_refiCnt = refiCnt;
    next_refreshDue = refreshDue;
    next_waitCnt = waitCnt;
    next_latCnt = latCnt;
    next_holdAck = holdAck;
    next_cmdN = CMD_NOP;
    next_allBanks = 1'b0;
    next_bankOut = bankOut;
    next_cmdOe = cmdOe;
    next_dataOut = dataOut;
    next_dataOe = 1'b0;
    next_strobeN = 1'b1;
    next_strobeAN = 1'b1;
    next_direction = 1'b0;
    next_startMark = 1'b0;
    next_endMark = 1'b0;
    next_ready = 1'b0;
    next_lastNormal = lastNormal;
    next_lastBank = lastBank;
    next_curDirect = curDirect;
    next_curBank = curBank;
    next_curData = curData;

    // interval counter is held at zero when the arbiter refreshes
    refiExpire = (scheme != SCH_ARBITER) && (refiCnt == REFI_W'(T_REFI_CYC - 1));
    if (scheme == SCH_ARBITER) begin
      next_refiCnt = '0;
    end else if (refiExpire) begin
      next_refiCnt = '0;
    end else begin
      next_refiCnt = refiCnt + 1'b1;
    end

    case (state)
      ST_IDLE: begin
        if (refreshDue) begin
          // refresh starts before any hold grant
          next_cmdN = CMD_REFRESH;
          next_waitCnt = WAIT_W'(T_RFC_CYC - 1);
          next_startMark = (scheme == SCH_START_END);
          next_refreshDue = 1'b0;
          next_state = ST_RFC;
        end else if (holdSync2) begin
          next_cmdN = CMD_DEACT;
          next_allBanks = 1'b1;
          next_state = ST_DEACT;
        end else if (wrValid) begin
          next_ready = 1'b1;
          next_curDirect = wrDirect;
          next_curBank = wrBank;
          next_curData = wrData;
          // a bus-turnaround gap keeps our data drivers off the peripheral's
          if (wrDirect && lastNormal && wrBank != lastBank) begin
            next_state = ST_TURN;
          end else begin
            next_state = ST_WRITE;
          end
        end
      end
      ST_RFC: begin
        // deactivate and hold ack wait out the full tRFC
        if (waitCnt != '0) begin
          next_waitCnt = waitCnt - 1'b1;
        end else begin
          next_endMark = (scheme == SCH_START_END);
          if (holdSync2) begin
            next_cmdN = CMD_DEACT;
            next_allBanks = 1'b1;
            next_state = ST_DEACT;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_DEACT: begin
        // release the pins and grant the bus
        next_holdAck = 1'b1;
        next_cmdOe = 1'b0;
        next_lastNormal = 1'b0;
        next_state = ST_HELD;
      end
      ST_HELD: begin
        if (!holdSync2) begin
          next_holdAck = 1'b0;
          next_cmdOe = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_TURN: begin
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        next_cmdN = CMD_WRITE;
        next_bankOut = curBank;
        next_lastBank = curBank;
        next_lastNormal = !curDirect;
        if (curDirect) begin
          // peripheral drives the data; strobes and direction held over latency
          next_strobeN = 1'b0;
          next_strobeAN = 1'b0;
          next_direction = 1'b1;
          next_latCnt = directWriteLatency;
          next_state = ST_DLAT;
        end else begin
          next_dataOut = curData;
          next_dataOe = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_DLAT: begin
        if (latCnt != 2'h0) begin
          next_latCnt = latCnt - 1'b1;
          next_strobeN = 1'b0;
          next_strobeAN = 1'b0;
          next_direction = 1'b1;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // expiry sets the flag even in the cycle it is taken
    if (refiExpire) begin
      next_refreshDue = 1'b1;
    end

    // pending mark for the arbiter, shown only in the pending scheme
    next_pending = (scheme == SCH_PENDING) &&
                   (next_refreshDue || next_state == ST_RFC ||
                    refiCnt >= REFI_W'(T_REFI_CYC - PEND_LEAD_CYC));
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      refiCnt <= '0;
      refreshDue <= 1'b0;
      waitCnt <= '0;
      latCnt <= 2'h0;
      holdAck <= 1'b0;
      cmdN <= CMD_NOP;
      allBanks <= 1'b0;
      bankOut <= 2'h0;
      cmdOe <= 1'b1;
      dataOut <= '0;
      dataOe <= 1'b0;
      strobeN <= 1'b1;
      strobeAN <= 1'b1;
      direction <= 1'b0;
      pending <= 1'b0;
      startMark <= 1'b0;
      endMark <= 1'b0;
      ready <= 1'b0;
      lastNormal <= 1'b0;
      lastBank <= 2'h0;
      curDirect <= 1'b0;
      curBank <= 2'h0;
      curData <= '0;
    end else if (ce) begin
      state <= next_state;
      refiCnt <= next_refiCnt;
      refreshDue <= next_refreshDue;
      waitCnt <= next_waitCnt;
      latCnt <= next_latCnt;
      holdAck <= next_holdAck;
      cmdN <= next_cmdN;
      allBanks <= next_allBanks;
      bankOut <= next_bankOut;
      cmdOe <= next_cmdOe;
      dataOut <= next_dataOut;
      dataOe <= next_dataOe;
      strobeN <= next_strobeN;
      strobeAN <= next_strobeAN;
      direction <= next_direction;
      pending <= next_pending;
      startMark <= next_startMark;
      endMark <= next_endMark;
      ready <= next_ready;
      lastNormal <= next_lastNormal;
      lastBank <= next_lastBank;
      curDirect <= next_curDirect;
      curBank <= next_curBank;
      curData <= next_curData;
    end
  end

  // ==========================================================
  // pins, all straight from flip-flops
  assign link.holdAck = holdAck;
  assign link.refreshPending = pending;
  assign link.refreshStart = startMark;
  assign link.refreshEnd = endMark;
  assign link.memCmdN = cmdN;
  assign link.memAllBanks = allBanks;
  assign link.memBank = bankOut;
  assign link.memCmdOe = cmdOe;
  assign link.memDataOut = dataOut;
  assign link.memDataOe = dataOe;
  assign link.directStrobeN = strobeN;
  assign link.directStrobeAN = strobeAN;
  assign link.directDirection = direction;
  assign wrReady = ready;
endmodule

// [hw/sdram_hold_pkg.sv]
// shared constants and types for the sdram hold / refresh / direct-write ends
package sdram_hold_pkg;
  // ==========================================================
  // clock and sdram timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RFC_NS = 70;
  localparam int T_REFI_NS = 7800;
  // least time rounds up, longest time rounds down
  localparam int T_RFC_CYC = (T_RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_REFI_CYC = (T_REFI_NS * 1000) / CLK_PERIOD_PS;
  localparam int PEND_LEAD_CYC = 16;
  // margin covers the two-stage synchronisers on both ends
  localparam int ARB_DONE_CYC = T_RFC_CYC + 4;
  localparam int REFI_W = 10;
  localparam int WAIT_W = 8;

  // ==========================================================
  // sdram command encoding {row strobe, column strobe, write enable}, low active
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_DEACT = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;

  // ==========================================================
  // refresh cooperation schemes
  typedef enum logic [1:0] {
    SCH_ARBITER = 2'h0,
    SCH_PENDING = 2'h1,
    SCH_START_END = 2'h2
  } refresh_scheme_t;
endpackage

// [hw/sdram_link_if.sv]
// link between the memory port end and the external bus arbiter
`timescale 1ns/1ps
interface sdram_link_if #(parameter int DATA_W = 32);
  // hold handshake
  logic holdReq;
  logic holdAck;
  // refresh timer outputs
  logic refreshPending;
  logic refreshStart;
  logic refreshEnd;
  // memory port command, data and direct-write pins
  logic [2:0] memCmdN;
  logic memAllBanks;
  logic [1:0] memBank;
  logic memCmdOe;
  logic [DATA_W-1:0] memDataOut;
  logic memDataOe;
  logic directStrobeN;
  logic directStrobeAN;
  logic directDirection;
  // arbiter command pins, driven only while it owns the bus
  logic [2:0] arbCmdN;
  logic arbCmdOe;

  modport device_end (
    input holdReq,
    output holdAck, refreshPending, refreshStart, refreshEnd,
    output memCmdN, memAllBanks, memBank, memCmdOe, memDataOut, memDataOe,
    output directStrobeN, directStrobeAN, directDirection
  );
  modport arbiter_end (
    output holdReq, arbCmdN, arbCmdOe,
    input holdAck, refreshPending, refreshStart, refreshEnd
  );
endinterface
